// ---- hw/gss_dev.sv ----
// sensor end: decodes command words and runs their actions
`timescale 1ns/1ps
module gss_dev
  import gss_pkg::*;
#(
  parameter longint unsigned REINIT_N = REINIT_CYC,
  parameter longint unsigned SHOT_FULL_N = SHOT_FULL_CYC,
  parameter longint unsigned SHOT_RHT_N = SHOT_RHT_CYC,
  parameter longint unsigned SLEEP_N = SLEEP_CYC,
  parameter longint unsigned WAKE_N = WAKE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  gss_if.dev lnk,
  // variant strap and sensing front end
  input wire logic high_accuracy,
  input wire logic [15:0] gas_sample,
  input wire logic [15:0] rh_sample,
  input wire logic [15:0] temp_sample,
  input wire logic [15:0] stored_cfg,
  // status
  output logic asleep,
  output logic busy,
  output logic reload_strobe,
  output logic [15:0] active_cfg,
  output logic auto_baseline_correction,
  output logic abc_allowed
);
  import gss_pkg::*;

  typedef enum logic [5:0] {
    GSS_IDLE = 6'b000001,
    GSS_REINIT = 6'b000010,
    GSS_FULL = 6'b000100,
    GSS_RHT = 6'b001000,
    GSS_TO_SLEEP = 6'b010000,
    GSS_SLEEP = 6'b100000
  } gss_state_t;

  gss_state_t state;
  gss_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic done;
  logic first_shot;
  logic var_ok;
  logic [2:0] strap_sync;

  assign done = (cnt == CNT_RESET);

  // ----------------------------------------
  // variant strap
  // ----------------------------------------
  // strap is a pin: three stages, a level counts once the last two agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_sync <= 3'h0;
      var_ok <= 1'b0;
    end else begin
      strap_sync <= {strap_sync[1:0], high_accuracy};
      if (strap_sync[2] == strap_sync[1]) begin
        var_ok <= strap_sync[2];
      end
    end
  end

  // ----------------------------------------
  // command decode and sequencing
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = (cnt == CNT_RESET) ? cnt : cnt - 32'h1;
    case (state)
      GSS_IDLE: begin
        if (lnk.cmd_valid) begin
          case (lnk.cmd_word)
            CMD_REINIT: begin
              next_state = GSS_REINIT;
              next_cnt = CNT_W'(REINIT_N - 1);
            end
            CMD_SHOT_FULL: begin
              if (var_ok) begin
                next_state = GSS_FULL;
                next_cnt = CNT_W'(SHOT_FULL_N - 1);
              end
            end
            CMD_SHOT_RHT: begin
              if (var_ok) begin
                next_state = GSS_RHT;
                next_cnt = CNT_W'(SHOT_RHT_N - 1);
              end
            end
            CMD_SLEEP: begin
              next_state = GSS_TO_SLEEP;
              next_cnt = CNT_W'(SLEEP_N - 1);
            end
            default: begin
              next_state = GSS_IDLE;
            end
          endcase
        end
      end
      GSS_REINIT, GSS_FULL, GSS_RHT: begin
        if (done) begin
          next_state = GSS_IDLE;
        end
      end
      GSS_TO_SLEEP: begin
        if (done) begin
          next_state = GSS_SLEEP;
        end
      end
      GSS_SLEEP: begin
        // wake is the only word heard while asleep
        if (done && lnk.cmd_valid && lnk.cmd_word == CMD_WAKE) begin
          next_state = GSS_IDLE;
          next_cnt = CNT_W'(WAKE_N - 1);
        end
      end
      default: begin
        next_state = GSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= GSS_IDLE;
      cnt <= CNT_RESET;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ----------------------------------------
  // link answers
  // ----------------------------------------
  // wake is not acknowledged; unknown or refused words are not either
  always_comb begin
    lnk.cmd_ack = 1'b0;
    if (lnk.cmd_valid && state == GSS_IDLE) begin
      lnk.cmd_ack = (lnk.cmd_word == CMD_REINIT) || (lnk.cmd_word == CMD_SLEEP) ||
        (var_ok && (lnk.cmd_word == CMD_SHOT_FULL || lnk.cmd_word == CMD_SHOT_RHT));
    end
  end

  // ----------------------------------------
  // measurement result
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.rd_valid <= 1'b0;
      lnk.rd_gas <= DATA_RESET;
      lnk.rd_rh <= DATA_RESET;
      lnk.rd_temp <= DATA_RESET;
    end else begin
      if (next_state != GSS_IDLE && state == GSS_IDLE) begin
        lnk.rd_valid <= 1'b0;
      end else if (done && state == GSS_FULL) begin
        lnk.rd_valid <= 1'b1;
        lnk.rd_gas <= gas_sample;
        lnk.rd_rh <= rh_sample;
        lnk.rd_temp <= temp_sample;
      end else if (done && state == GSS_RHT) begin
        lnk.rd_valid <= 1'b1;
        lnk.rd_gas <= GAS_ZERO;
        lnk.rd_rh <= rh_sample;
        lnk.rd_temp <= temp_sample;
      end
    end
  end

  // ----------------------------------------
  // settings reload
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_strobe <= 1'b0;
      active_cfg <= DATA_RESET;
    end else begin
      reload_strobe <= done && state == GSS_REINIT;
      if (done && state == GSS_REINIT) begin
        active_cfg <= stored_cfg;
      end
    end
  end

  // ----------------------------------------
  // baseline correction
  // ----------------------------------------
  // a sleep cycle breaks the history; cleared until next reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_baseline_correction <= 1'b1;
      first_shot <= 1'b1;
    end else begin
      if (state == GSS_TO_SLEEP) begin
        auto_baseline_correction <= 1'b0;
      end
      if (done && (state == GSS_FULL)) begin
        first_shot <= 1'b0;
      end
    end
  end

  assign abc_allowed = auto_baseline_correction && !first_shot;
  assign asleep = (state == GSS_SLEEP);
  assign busy = (state != GSS_IDLE) && (state != GSS_SLEEP);
endmodule // gss_dev

// ---- hw/gss_host.sv ----
// host end: issues command words and waits out their durations
`timescale 1ns/1ps
module gss_host
  import gss_pkg::*;
#(
  parameter longint unsigned REINIT_N = REINIT_CYC,
  parameter longint unsigned SHOT_FULL_N = SHOT_FULL_CYC,
  parameter longint unsigned SHOT_RHT_N = SHOT_RHT_CYC,
  parameter longint unsigned SLEEP_N = SLEEP_CYC,
  parameter longint unsigned WAKE_N = WAKE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  gss_if.hst lnk,
  // user request
  input wire logic req_valid,
  input wire logic [15:0] req_cmd,
  output logic req_ready,
  // result
  output logic res_valid,
  output logic [15:0] res_gas,
  output logic [15:0] res_rh,
  output logic [15:0] res_temp,
  output logic res_first
);
  import gss_pkg::*;

  logic [CNT_W-1:0] wait_cnt;
  logic periodic_stopped;
  logic first_seen;
  logic [CNT_W-1:0] dur;

  // reinit only once periodic mode is stopped
  assign req_ready = (wait_cnt == CNT_RESET) &&
    !(req_cmd == CMD_REINIT && !periodic_stopped);
  assign lnk.cmd_valid = req_valid && req_ready;
  assign lnk.cmd_word = req_cmd;

  always_comb begin
    case (req_cmd)
      CMD_REINIT: dur = CNT_W'(REINIT_N);
      CMD_SHOT_FULL: dur = CNT_W'(SHOT_FULL_N);
      CMD_SHOT_RHT: dur = CNT_W'(SHOT_RHT_N);
      CMD_SLEEP: dur = CNT_W'(SLEEP_N);
      CMD_WAKE: dur = CNT_W'(WAKE_N);
      default: dur = 32'h1;
    endcase
  end

  // ----------------------------------------
  // command spacing
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= CNT_RESET;
      periodic_stopped <= 1'b0;
    end else begin
      if (lnk.cmd_valid) begin
        wait_cnt <= dur;
        if (req_cmd == CMD_STOP_PERIODIC) begin
          periodic_stopped <= 1'b1;
        end
      end else if (wait_cnt != CNT_RESET) begin
        wait_cnt <= wait_cnt - 32'h1;
      end
    end
  end

  // ----------------------------------------
  // readout, first shot flagged for discard
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
      res_gas <= DATA_RESET;
      res_rh <= DATA_RESET;
      res_temp <= DATA_RESET;
      res_first <= 1'b0;
      first_seen <= 1'b0;
    end else begin
      res_valid <= 1'b0;
      if (lnk.cmd_valid && req_cmd == CMD_READ_MEAS && lnk.rd_valid) begin
        res_valid <= 1'b1;
        res_gas <= lnk.rd_gas;
        res_rh <= lnk.rd_rh;
        res_temp <= lnk.rd_temp;
        res_first <= !first_seen;
        first_seen <= 1'b1;
      end
    end
  end
endmodule // gss_host

// ---- hw/gss_if.sv ----
// command link between host and sensor handler
`timescale 1ns/1ps
interface gss_if;
  logic cmd_valid;
  logic [15:0] cmd_word;
  logic cmd_ack;
  logic rd_valid;
  logic [15:0] rd_gas;
  logic [15:0] rd_rh;
  logic [15:0] rd_temp;
  modport dev (input cmd_valid, input cmd_word, output cmd_ack, output rd_valid,
    output rd_gas, output rd_rh, output rd_temp);
  modport hst (output cmd_valid, output cmd_word, input cmd_ack, input rd_valid,
    input rd_gas, input rd_rh, input rd_temp);
endinterface

// ---- hw/gss_pkg.sv ----
// shared constants for the single shot command handler
package gss_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam logic [15:0] CMD_REINIT = 16'h3646;
  localparam logic [15:0] CMD_SHOT_FULL = 16'h219D;
  localparam logic [15:0] CMD_SHOT_RHT = 16'h2196;
  localparam logic [15:0] CMD_SLEEP = 16'h36E0;
  localparam logic [15:0] CMD_WAKE = 16'h36F6;
  localparam logic [15:0] CMD_STOP_PERIODIC = 16'h3F86;
  localparam logic [15:0] CMD_READ_MEAS = 16'hEC05;
  // maximum command durations in ms
  localparam int unsigned REINIT_MS = 30;
  localparam int unsigned SHOT_FULL_MS = 5000;
  localparam int unsigned SHOT_RHT_MS = 50;
  localparam int unsigned SLEEP_MS = 1;
  localparam int unsigned WAKE_MS = 30;
  localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
  localparam longint unsigned REINIT_CYC = longint'(REINIT_MS) * CYC_PER_MS;
  localparam longint unsigned SHOT_FULL_CYC = longint'(SHOT_FULL_MS) * CYC_PER_MS;
  localparam longint unsigned SHOT_RHT_CYC = longint'(SHOT_RHT_MS) * CYC_PER_MS;
  localparam longint unsigned SLEEP_CYC = longint'(SLEEP_MS) * CYC_PER_MS;
  localparam longint unsigned WAKE_CYC = longint'(WAKE_MS) * CYC_PER_MS;
  // self-correction tuned interval between measurements
  localparam int unsigned ABC_INTERVAL_MIN = 5;
  localparam int unsigned CNT_W = 32;
  localparam logic [31:0] CNT_RESET = 32'h0;
  localparam logic [15:0] GAS_ZERO = 16'h0;
  localparam logic [15:0] DATA_RESET = 16'h0;
endpackage

// ---- tb/gas_sensor_single_shot_cmds_tb_top.sv ----
// self-checking bench: host and sensor ends joined over the command link
`timescale 1ns/1ps
module gas_sensor_single_shot_cmds_tb_top;
  import gss_pkg::*;
  localparam longint unsigned FULL_N = 20;
  localparam longint unsigned REINIT_T = 5;
  localparam longint unsigned RHT_T = 8;
  localparam longint unsigned SLEEP_T = 3;
  localparam longint unsigned WAKE_T = 6;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic high_accuracy = 1'b1;
  logic [15:0] gas_sample = 16'h0190;
  logic [15:0] rh_sample = 16'h6A3C;
  logic [15:0] temp_sample = 16'h5E12;
  logic [15:0] stored_cfg = 16'hA5C3;
  logic req_valid = 1'b0;
  logic [15:0] req_cmd = 16'h0;
  logic req_ready, res_valid, res_first, cap_first, asleep, busy, reload_strobe, abc_on, abc_ok;
  logic [15:0] res_gas, res_rh, res_temp, active_cfg, cap_gas, cap_rh, cap_temp;
  int errors = 0;
  int n_checks = 0;
  int n_ack = 0;
  int n_res = 0;
  int n_reload = 0;
  int cycles = 0;
  int mark;
  gss_if lnk();
  gss_dev #(.REINIT_N(REINIT_T), .SHOT_FULL_N(FULL_N), .SHOT_RHT_N(RHT_T),
    .SLEEP_N(SLEEP_T), .WAKE_N(WAKE_T))
  u_gss_dev (.clk(clk), .rst_n(rst_n), .lnk(lnk.dev), .high_accuracy(high_accuracy),
    .gas_sample(gas_sample), .rh_sample(rh_sample), .temp_sample(temp_sample),
    .stored_cfg(stored_cfg), .asleep(asleep), .busy(busy), .reload_strobe(reload_strobe),
    .active_cfg(active_cfg), .auto_baseline_correction(abc_on), .abc_allowed(abc_ok));
  gss_host #(.REINIT_N(REINIT_T), .SHOT_FULL_N(FULL_N), .SHOT_RHT_N(RHT_T),
    .SLEEP_N(SLEEP_T), .WAKE_N(WAKE_T))
  u_gss_host (.clk(clk), .rst_n(rst_n), .lnk(lnk.hst), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_ready(req_ready), .res_valid(res_valid), .res_gas(res_gas),
    .res_rh(res_rh), .res_temp(res_temp), .res_first(res_first));
  gss_link_props #(.SHOT_FULL_N(FULL_N), .SHOT_RHT_N(RHT_T)) u_gss_link_props (.clk(clk),
    .rst_n(rst_n), .cmd_valid(lnk.cmd_valid), .cmd_word(lnk.cmd_word), .cmd_ack(lnk.cmd_ack),
    .rd_valid(lnk.rd_valid), .rd_gas(lnk.rd_gas), .rd_rh(lnk.rd_rh), .rd_temp(lnk.rd_temp));
  always #2 clk = ~clk;
  // result pulse lasts one cycle, so it is caught here
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (lnk.cmd_ack === 1'b1) n_ack <= n_ack + 1;
    if (reload_strobe === 1'b1) n_reload <= n_reload + 1;
    if (res_valid === 1'b1) begin
      n_res <= n_res + 1;
      cap_gas <= res_gas;
      cap_rh <= res_rh;
      cap_temp <= res_temp;
      cap_first <= res_first;
    end
    if (cycles == 2000) begin
      errors++;
      close_out();
    end
  end
  // ----
  // tasks
  // ----
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // ready is read a cycle after the word changes, so the host has settled
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (req_ready !== 1'b1 && k < 200);
    if (req_ready !== 1'b1) errors++;
    // one spare cycle lets one-cycle pulses reach the counters
    @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [15:0] c);
    req_cmd = c;
    wait_idle();
    req_valid = 1'b1;
    @(posedge clk);
    #1 req_valid = 1'b0;
  endtask
  task automatic fetch();
    int k;
    k = n_res;
    send(CMD_READ_MEAS);
    repeat (20) if (n_res == k) @(posedge clk);
    #1;
    chk(16'(n_res - k), 16'h1);
  endtask
  task automatic close_out();
    $display("checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ----
  // tests
  // ----
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    req_cmd = CMD_REINIT;
    req_valid = 1'b1;
    @(posedge clk);
    #1 chk(16'(req_ready), 16'h0);
    chk(16'(n_ack), 16'h0);
    req_valid = 1'b0;
    send(CMD_STOP_PERIODIC);
    send(CMD_REINIT);
    wait_idle();
    chk(active_cfg, 16'hA5C3);
    chk(16'(n_reload), 16'h1);
    chk(16'(abc_on), 16'h1);
    chk(16'(abc_ok), 16'h0);
    send(CMD_SHOT_FULL);
    chk(16'(busy), 16'h1);
    chk(16'(req_ready), 16'h0);
    fetch();
    chk(cap_gas, 16'h0190);
    chk(cap_rh, 16'h6A3C);
    chk(cap_temp, 16'h5E12);
    chk(16'(cap_first), 16'h1);
    chk(16'(abc_ok), 16'h1);
    gas_sample = 16'h01F4;
    send(CMD_SHOT_FULL);
    fetch();
    chk(cap_gas, 16'h01F4);
    chk(16'(cap_first), 16'h0);
    send(CMD_SHOT_RHT);
    fetch();
    chk(cap_gas, GAS_ZERO);
    chk(cap_temp, 16'h5E12);
    high_accuracy = 1'b0;
    // strap passes a three-stage synchroniser before it counts
    repeat (4) @(posedge clk);
    #1;
    mark = n_ack;
    send(CMD_SHOT_FULL);
    wait_idle();
    chk(16'(n_ack - mark), 16'h0);
    high_accuracy = 1'b1;
    send(CMD_SLEEP);
    wait_idle();
    chk(16'(asleep), 16'h1);
    chk(16'(abc_on), 16'h0);
    chk(16'(abc_ok), 16'h0);
    mark = n_ack;
    send(CMD_SHOT_RHT);
    send(CMD_WAKE);
    wait_idle();
    chk(16'(n_ack - mark), 16'h0);
    chk(16'(asleep), 16'h0);
    send(CMD_SHOT_RHT);
    fetch();
    chk(cap_rh, 16'h6A3C);
    close_out();
  end
endmodule // gas_sensor_single_shot_cmds_tb_top

// ---- tb/gss_link_properties.sv ----
// assertions on the command link between host and sensor ends
`timescale 1ns/1ps
module gss_link_props
  import gss_pkg::*;
#(
  parameter longint unsigned SHOT_FULL_N = 20,
  parameter longint unsigned SHOT_RHT_N = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic cmd_ack,
  input wire logic rd_valid,
  input wire logic [15:0] rd_gas,
  input wire logic [15:0] rd_rh,
  input wire logic [15:0] rd_temp
);
  // first eight quiet cycles are spelled out, the rest ride the range
  localparam int FULL_LO = int'(SHOT_FULL_N) - 8;
  localparam int FULL_HI = int'(SHOT_FULL_N) - 7;
  localparam int RHT_LO = int'(SHOT_RHT_N);
  localparam int RHT_HI = int'(SHOT_RHT_N) + 1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_full; cmd_ack && cmd_word == CMD_SHOT_FULL; endsequence
  sequence s_rht; cmd_ack && cmd_word == CMD_SHOT_RHT; endsequence
  sequence s_full_wait; (!rd_valid) [*8] ##[FULL_LO:FULL_HI] rd_valid; endsequence
  a_wake_not_acked: assert property (cmd_valid && cmd_word == CMD_WAKE |-> !cmd_ack)
    else $error("wake word was acknowledged");
  a_full_shot_time: assert property (s_full |=> s_full_wait)
    else $error("full shot result not ready on time");
  a_rht_gas_zero: assert property (s_rht |-> ##[RHT_LO:RHT_HI] (rd_valid && rd_gas == GAS_ZERO))
    else $error("rht shot result late or gas not zero");
  a_result_holds: assert property (rd_valid && !cmd_valid |=>
    rd_valid && $stable(rd_gas) && $stable(rd_rh) && $stable(rd_temp))
    else $error("result changed with no command");
  a_ack_needs_valid: assert property (cmd_ack |-> cmd_valid)
    else $error("ack with no command");
  a_busy_refuses: assert property (s_full |=> (!cmd_ack) [*8])
    else $error("command taken while busy");
  a_reinit_silent: assert property (cmd_ack && cmd_word == CMD_REINIT |=> (!rd_valid) [*6])
    else $error("reinit raised a result");
  a_sleep_settles: assert property (cmd_ack && cmd_word == CMD_SLEEP |=> (!cmd_ack) [*3])
    else $error("command taken during sleep entry");
endmodule // gss_link_props
